// ### include/rx_status_regs.vh
`ifndef RX_STATUS_REGS_VH
`define RX_STATUS_REGS_VH
// Status word bit positions.
`define BIT_TOO_LONG 7
`define BIT_LATE_COL 6
`define BIT_ETHERTYPE 5
`define BIT_WATCHDOG 4
`define BIT_MII_ERR 3
`define BIT_DRIBBLE 2
`define BIT_CRC_ERR 1
`define BIT_RESERVED 0
// Length limits in bytes.
`define MAX_LEN_PLAIN 16'h05EE
`define MAX_LEN_VLAN 16'h05F2
`define ETHERTYPE_MIN 16'h0600
`define RUNT_TYPE_LEN 16'h000E
`define WDOG_LEN_LOW 16'h0800
`define WDOG_LEN_HIGH 16'h0A00
// Dribble thresholds in bits.
`define DRIB_MII_BITS 3'h4
`define DRIB_SER_BITS 3'h3
`endif

// ### rtl/rx_descriptor_status_encoder.v
`include "rx_status_regs.vh"
`default_nettype none
// Behaviour
// - Too-long flag when length exceeds 1518, or 1522 with VLAN enabled.
// - Too-long flag bit 7 is meaningful only with the final-descriptor flag.
// - Over-length frames are only flagged, never truncated.
// - Late-collision flag bit 6 on collision after the collision window.
// - Ethertype flag bit 5 when length/type field is at least 1536.
// - Ethertype flag meaningless for runts under 14 bytes.
// - Watchdog flag bit 4 on timer expiry for frames of 2049 to 2560 bytes.
// - MII-error flag bit 3 when RX_ER seen any time in the frame.
// - Dribble flag bit 2 when the bit length is not a byte multiple.
// - Dribble needs 4 extra bits in MII mode, at least 3 in serial.
// - Dribble flag is not valid when late collision is set.
// - CRC-error flag bit 1 when the frame check sequence mismatches.
// - CRC-error flag also set when RX_ER was seen during the frame.
// - CRC-error flag invalid for runts, collisions and watchdog timeouts.
// - Bit 0 is reserved and always written as zero.
// - Error summary is OR of CRC, late collision, too long, runt, descriptor error.
// - Final-descriptor flag marks the last buffers and validates end status.
module rx_descriptor_status_encoder #(
   parameter LEN_W = 14
) (
   // Clock and reset.
   input wire REF_CLK,
   input wire RST_N,
   // Configuration.
   input wire VLAN_EN,
   input wire SERIAL_MODE,
   // Receive MAC events, all on REF_CLK.
   input wire FRAME_START,
   input wire FRAME_END,
   input wire BYTE_STROBE,
   input wire [15:0] TYPE_LEN,
   input wire TYPE_LEN_VALID,
   input wire LATE_COLLISION,
   input wire WATCHDOG_EXPIRED,
   input wire FCS_MISMATCH,
   input wire [2:0] DRIBBLE_BITS,
   input wire RUNT,
   input wire DESC_ERROR,
   // Receive error straight from the internal MII, asynchronous.
   input wire RX_ER,
   // Write-back request from the DMA path.
   input wire WRITEBACK,
   input wire LAST_DESC,
   // Status word toward host memory.
   output wire [7:0] RX_STATUS_WORD,
   output wire FINAL_DESCRIPTOR_FLAG,
   output wire ERROR_SUMMARY_FLAG,
   output wire STATUS_VALID,
   output wire [LEN_W-1:0] FRAME_BYTES
);
   // -----------------------------------------------------------------
   // Input synchronisation
   // -----------------------------------------------------------------
   wire rx_er_s;

   rx_pin_sync #(
      .W(1)
   ) u_sync (
      .REF_CLK(REF_CLK),
      .RST_N(RST_N),
      .d(RX_ER),
      .q(rx_er_s)
   );

   // -----------------------------------------------------------------
   // Per-frame accumulation
   // -----------------------------------------------------------------
   reg [LEN_W-1:0] len_r;
   reg late_col_r;
   reg wdog_r;
   reg mii_err_r;
   reg fcs_bad_r;
   reg ethertype_r;
   reg runt_r;
   reg desc_err_r;
   reg [2:0] drib_r;
   reg in_frame_r;

   // Length comparisons use 16 bits so a narrow counter still compares cleanly.
   function over_limit;
      input [15:0] len;
      input [15:0] lim;
      begin
         over_limit = (len > lim);
      end
   endfunction

   wire [15:0] len16 = {{(16-LEN_W){1'b0}}, len_r};

   // Sticky flags: a start clears, but an event in the same cycle still sets.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         len_r <= {LEN_W{1'b0}};
         late_col_r <= 1'b0;
         wdog_r <= 1'b0;
         mii_err_r <= 1'b0;
         fcs_bad_r <= 1'b0;
         ethertype_r <= 1'b0;
         runt_r <= 1'b0;
         desc_err_r <= 1'b0;
         drib_r <= 3'h0;
         in_frame_r <= 1'b0;
      end else begin
         if (FRAME_START) begin
            len_r <= {{(LEN_W-1){1'b0}}, BYTE_STROBE};
            late_col_r <= LATE_COLLISION;
            wdog_r <= WATCHDOG_EXPIRED;
            mii_err_r <= rx_er_s;
            fcs_bad_r <= 1'b0;
            ethertype_r <= 1'b0;
            runt_r <= 1'b0;
            desc_err_r <= 1'b0;
            drib_r <= 3'h0;
            in_frame_r <= 1'b1;
         end else begin
            // The counter saturates; overlong frames are passed whole.
            if (BYTE_STROBE && in_frame_r && len_r != {LEN_W{1'b1}}) begin
               len_r <= len_r + {{(LEN_W-1){1'b0}}, 1'b1};
            end
            if (LATE_COLLISION && in_frame_r) begin
               late_col_r <= 1'b1;
            end
            if (WATCHDOG_EXPIRED && in_frame_r) begin
               wdog_r <= 1'b1;
            end
            if (rx_er_s && in_frame_r) begin
               mii_err_r <= 1'b1;
            end
            if (TYPE_LEN_VALID && in_frame_r) begin
               ethertype_r <= (TYPE_LEN >= `ETHERTYPE_MIN);
            end
            if (FRAME_END && in_frame_r) begin
               fcs_bad_r <= FCS_MISMATCH;
               runt_r <= RUNT;
               desc_err_r <= DESC_ERROR;
               drib_r <= DRIBBLE_BITS;
               in_frame_r <= 1'b0;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Status word assembly
   // -----------------------------------------------------------------
   wire too_long = over_limit(len16, VLAN_EN ? `MAX_LEN_VLAN : `MAX_LEN_PLAIN);
   // Watchdog only counts inside its documented length band.
   wire wdog_hit = wdog_r && over_limit(len16, `WDOG_LEN_LOW) &&
      !over_limit(len16, `WDOG_LEN_HIGH);
   wire drib_hit = SERIAL_MODE ? (drib_r >= `DRIB_SER_BITS)
      : (drib_r == `DRIB_MII_BITS);
   // A runt has no trustworthy type field, so the bit is forced clear.
   wire type_ok = ethertype_r && !over_limit(`RUNT_TYPE_LEN, len16);
   // Dribble is suppressed under late collision so it never misleads.
   wire drib_flag = drib_hit && !late_col_r;
   wire crc_flag = fcs_bad_r || mii_err_r;

   reg [7:0] word_r;
   reg final_r;
   reg summary_r;
   reg valid_r;
   reg [LEN_W-1:0] bytes_r;
   reg [7:0] word_nxt;

   // End-of-frame bits are only filled in the last descriptor.
   always @* begin
      word_nxt = 8'h00;
      if (LAST_DESC) begin
         word_nxt[`BIT_TOO_LONG] = too_long;
         word_nxt[`BIT_LATE_COL] = late_col_r;
         word_nxt[`BIT_ETHERTYPE] = type_ok;
         word_nxt[`BIT_WATCHDOG] = wdog_hit;
         word_nxt[`BIT_MII_ERR] = mii_err_r;
         word_nxt[`BIT_DRIBBLE] = drib_flag;
         // CRC is reported as computed; the host judges the frame on it even when not valid.
         word_nxt[`BIT_CRC_ERR] = crc_flag;
      end
      word_nxt[`BIT_RESERVED] = 1'b0;
   end

   // Write-back register: one word per descriptor closed.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         word_r <= 8'h00;
         final_r <= 1'b0;
         summary_r <= 1'b0;
         valid_r <= 1'b0;
         bytes_r <= {LEN_W{1'b0}};
      end else begin
         valid_r <= WRITEBACK;
         if (WRITEBACK) begin
            word_r <= word_nxt;
            final_r <= LAST_DESC;
            summary_r <= LAST_DESC && (crc_flag || late_col_r || too_long ||
               runt_r || desc_err_r);
            bytes_r <= len_r;
         end
      end
   end

   assign RX_STATUS_WORD = word_r;
   assign FINAL_DESCRIPTOR_FLAG = final_r;
   assign ERROR_SUMMARY_FLAG = summary_r;
   assign STATUS_VALID = valid_r;
   assign FRAME_BYTES = bytes_r;
endmodule
`default_nettype wire

// ### rtl/rx_pin_sync.v
`default_nettype none
// Two-stage synchroniser for a bundle of asynchronous levels.
module rx_pin_sync #(
   parameter W = 1
) (
   input wire REF_CLK,
   input wire RST_N,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // Only the second stage is read outside this module.
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end
   assign q = sync_r;
endmodule
`default_nettype wire

// ### testbench/rx_descriptor_status_encoder_tb.sv
`include "rx_status_regs.vh"
`default_nettype none
module rx_descriptor_status_encoder_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ---
   // Frames in, descriptor words judged
   // ---
   logic clk = 0, rst_n = 0, vlan = 0, ser = 0, fs = 0, fe = 0, bs = 0, tv = 0, lc = 0;
   logic wd = 0, fcs = 0, runt = 0, de = 0, rxer = 0, wb = 0, ld = 0;
   logic [15:0] tl = 16'h0000;
   logic [2:0] db = 3'h0;
   wire [7:0] word;
   wire [13:0] nb;
   wire fin, sum, sv, ok;
   int errors = 0, check_count = 0, cyc = 0;
   rx_descriptor_status_encoder u_dut (.REF_CLK(clk), .RST_N(rst_n), .VLAN_EN(vlan),
      .SERIAL_MODE(ser), .FRAME_START(fs), .FRAME_END(fe), .BYTE_STROBE(bs), .TYPE_LEN(tl),
      .TYPE_LEN_VALID(tv), .LATE_COLLISION(lc), .WATCHDOG_EXPIRED(wd), .FCS_MISMATCH(fcs),
      .DRIBBLE_BITS(db), .RUNT(runt), .DESC_ERROR(de), .RX_ER(rxer), .WRITEBACK(wb),
      .LAST_DESC(ld), .RX_STATUS_WORD(word), .FINAL_DESCRIPTOR_FLAG(fin),
      .ERROR_SUMMARY_FLAG(sum), .STATUS_VALID(sv), .FRAME_BYTES(nb));
   rx_host_model u_host (.clk(clk), .valid(sv), .last(fin), .word(word), .ok(ok));
   // Clock, and a cycle ceiling well above the longest run of frames.
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Event bits: 0 late collision, 1 watchdog, 2 fcs, 3 rx error, 4 runt, 5 descriptor error.
   task frame(input int n, input logic [15:0] t, input logic [5:0] ev, input logic [2:0] d,
              input logic last);
      logic [7:0] e;
      logic tlf, ce;
      @(negedge clk) {fs, bs, tv, tl, lc, wd, rxer} = {3'h6, t, ev[0], ev[1], ev[3]};
      // The type field is only taken once the frame is open, so it follows the start.
      @(negedge clk) {fs, tv, lc, wd} = 4'h4;
      @(negedge clk) tv = 0;
      repeat (n - 2) @(negedge clk);
      {bs, fe, fcs, runt, de, db, rxer} = {2'h1, ev[2], ev[4], ev[5], d, 1'b0};
      @(negedge clk) {fe, wb, ld} = {2'h1, last};
      @(negedge clk) wb = 0;
      tlf = n > (vlan ? `MAX_LEN_VLAN : `MAX_LEN_PLAIN);
      ce = ev[2] | ev[3];
      e = {tlf, ev[0], n >= `RUNT_TYPE_LEN && t >= `ETHERTYPE_MIN,
           ev[1] && n > `WDOG_LEN_LOW && n <= `WDOG_LEN_HIGH, ev[3],
           !ev[0] && (ser ? d >= `DRIB_SER_BITS : d == `DRIB_MII_BITS), ce, 1'b0};
      chk(sv, 1'b1);
      chk(word, last ? e : 8'h00);
      chk(sum, last && (tlf | ev[0] | ce | ev[4] | ev[5]));
      chk(nb, n[15:0]);
      chk(fin, last);
      @(negedge clk) chk(ok, last && !ce);
   endtask
   task len_limits;
      frame(16'h05EE, 16'h0600, 6'h00, 3'h0, 1);
      frame(16'h05EF, 16'h0600, 6'h00, 3'h0, 1);
      vlan = 1;
      frame(16'h05F2, 16'h05FF, 6'h00, 3'h0, 1);
      frame(16'h05F3, 16'h05FF, 6'h00, 3'h0, 1);
      vlan = 0;
   endtask
   task type_and_errors;
      frame(16'h000E, 16'h0600, 6'h00, 3'h0, 1);
      frame(16'h000D, 16'h0600, 6'h10, 3'h0, 1);
      frame(16'h0040, 16'h0000, 6'h01, 3'h4, 1);
      frame(16'h0800, 16'h0000, 6'h02, 3'h0, 1);
      frame(16'h0801, 16'h0000, 6'h02, 3'h0, 1);
      frame(16'h0040, 16'h0000, 6'h08, 3'h0, 1);
      frame(16'h0040, 16'h0000, 6'h24, 3'h0, 1);
   endtask
   task dribble_modes;
      for (int i = 0; i < 4; i++) begin
         ser = i[1];
         frame(16'h0040, 16'h0000, 6'h00, 3'h3 + i[0], 1);
      end
      ser = 0;
   endtask
   task desc_close;
      frame(16'h0040, 16'h0600, 6'h3F, 3'h4, 0);
      frame(16'h0040, 16'h0600, 6'h3F, 3'h4, 1);
      frame(16'h0040, 16'h0000, 6'h00, 3'h0, 1);
   endtask
   task end_of_test;
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Reset for sixteen cycles, then each scenario in turn.
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1;
      len_limits();
      type_and_errors();
      dribble_modes();
      desc_close();
      end_of_test();
   end
endmodule
`default_nettype wire

// ### testbench/rx_host_model.sv
`default_nettype none
// ---
// Host driver model
// ---
module rx_host_model (
   // Descriptor write-back as the host sees it.
   input wire logic clk,
   input wire logic valid,
   input wire logic last,
   input wire logic [7:0] word,
   // Frame judged good.
   output logic ok
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bit 0 is never looked at; a dribble alone does not spoil a frame.
   always @(posedge clk) begin
      if (valid) begin
         ok <= last && !word[1];
      end
   end
endmodule
`default_nettype wire

// ### testbench/rx_status_chk.sv
`include "rx_status_regs.vh"
`default_nettype none
// ---
// Status word checks
// ---
module rx_status_chk #(parameter LEN_W = 14) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic WRITEBACK,
   input wire logic LAST_DESC,
   input wire logic [7:0] RX_STATUS_WORD,
   input wire logic FINAL_DESCRIPTOR_FLAG,
   input wire logic ERROR_SUMMARY_FLAG,
   input wire logic STATUS_VALID,
   input wire logic [LEN_W-1:0] FRAME_BYTES
);
   // Shorthands for a closed final descriptor and its word.
   wire f = STATUS_VALID && FINAL_DESCRIPTOR_FLAG;
   wire [7:0] w = RX_STATUS_WORD;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   a_valid_resp: assert property (WRITEBACK |=> STATUS_VALID) else $error("no valid");
   a_final_copy: assert property (WRITEBACK |=> FINAL_DESCRIPTOR_FLAG == $past(LAST_DESC))
      else $error("final flag");
   a_rsvd_zero: assert property (!w[0]) else $error("bit 0 set");
   a_nonlast_clear: assert property (STATUS_VALID && !FINAL_DESCRIPTOR_FLAG |->
      w[7:1] == 7'h00 && !ERROR_SUMMARY_FLAG) else $error("non-last flags");
   a_sum_or: assert property (f && (w[1] | w[6] | w[7]) |-> ERROR_SUMMARY_FLAG)
      else $error("summary");
   a_drib_mask: assert property (STATUS_VALID && w[6] |-> !w[2]) else $error("dribble");
   a_crc_mii: assert property (STATUS_VALID && w[3] |-> w[1]) else $error("crc");
   a_runt_type: assert property (f && FRAME_BYTES < `RUNT_TYPE_LEN |-> !w[5])
      else $error("runt type");
   a_wdog_range: assert property (STATUS_VALID && w[4] |->
      FRAME_BYTES > `WDOG_LEN_LOW && FRAME_BYTES <= `WDOG_LEN_HIGH) else $error("watchdog");
endmodule
bind rx_descriptor_status_encoder rx_status_chk #(.LEN_W(LEN_W)) u_chk (.REF_CLK(REF_CLK),
   .RST_N(RST_N), .WRITEBACK(WRITEBACK), .LAST_DESC(LAST_DESC), .STATUS_VALID(STATUS_VALID),
   .RX_STATUS_WORD(RX_STATUS_WORD), .FINAL_DESCRIPTOR_FLAG(FINAL_DESCRIPTOR_FLAG),
   .ERROR_SUMMARY_FLAG(ERROR_SUMMARY_FLAG), .FRAME_BYTES(FRAME_BYTES));
`default_nettype wire
